// File: hdl/qeq_dev.sv
// Management slave and configuration registers of the quad equalizer
`include "qeq_consts.svh"
module qeq_dev
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    qeq_if.dev              bus,
    input  wire logic [3:0] signal_present,
    input  wire logic [3:0] chan_enable_pin,
    output logic      [3:0] chan_active,
    output logic      [2:0] boost_ch0,
    output logic      [2:0] boost_ch1,
    output logic      [2:0] boost_ch2,
    output logic      [2:0] boost_ch3,
    output logic      [7:0] detect_rise_level,
    output logic      [7:0] detect_fall_level,
    output logic      [1:0] swing_code
);
    // ****************************************
    // Input synchronisers and edge detection
    // ****************************************
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic [1:0] cs_s_r;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            cs_s_r  <= 2'h0;
        end
        else
        begin
            scl_s_r <= {scl_s_r[1:0], bus.serial_clock_pin};
            sda_s_r <= {sda_s_r[1:0], bus.sda};
            cs_s_r  <= {cs_s_r[0], bus.chip_sel};
        end
    end
    logic scl;
    logic sda;
    logic sel;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl       = scl_s_r[1];
    assign sda       = sda_s_r[1];
    assign sel       = cs_s_r[1];
    assign scl_rise  = scl && !scl_s_r[2];
    assign scl_fall  = !scl && scl_s_r[2];
    assign start_det = sel && scl && scl_s_r[2] && !sda && sda_s_r[2];
    assign stop_det  = scl && scl_s_r[2] && sda && !sda_s_r[2];

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] ctrl_lo_r;
    logic [7:0] ctrl_hi_r;
    logic [7:0] rise_thr_r;
    logic [7:0] fall_thr_r;
    logic [7:0] src_sel_r;
    logic [7:0] swing_r;
    logic [7:0] index_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic       reading_r;
    logic       sda_drive_r;
    qeq_pkg::qeq_slv_state_t state_r;
    logic       wr_stb;
    logic [7:0] rd_byte;

    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        unique case (idx)
            `QEQ_IDX_STATUS0:  reg_read = {`QEQ_REVISION, signal_present};
            `QEQ_IDX_STATUS1:  reg_read = {chan_active[1], ctrl_lo_r[6:4],
                                           chan_active[0], ctrl_lo_r[2:0]};
            `QEQ_IDX_STATUS2:  reg_read = {chan_active[3], ctrl_hi_r[6:4],
                                           chan_active[2], ctrl_hi_r[2:0]};
            `QEQ_IDX_CTRL_LO:  reg_read = ctrl_lo_r;
            `QEQ_IDX_CTRL_HI:  reg_read = ctrl_hi_r;
            `QEQ_IDX_RISE_THR: reg_read = rise_thr_r;
            `QEQ_IDX_FALL_THR: reg_read = fall_thr_r;
            `QEQ_IDX_SRC_SEL:  reg_read = src_sel_r;
            `QEQ_IDX_SWING:    reg_read = swing_r;
            default:           reg_read = 8'h00;
        endcase
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_lo_r  <= `QEQ_RST_CTRL;
            ctrl_hi_r  <= `QEQ_RST_CTRL;
            rise_thr_r <= `QEQ_RST_THR;
            fall_thr_r <= `QEQ_RST_THR;
            src_sel_r  <= `QEQ_RST_SRC;
            swing_r    <= `QEQ_RST_SWING;
        end
        else if (wr_stb)
        begin
            unique case (index_r)
                `QEQ_IDX_CTRL_LO:  ctrl_lo_r  <= shift_r;
                `QEQ_IDX_CTRL_HI:  ctrl_hi_r  <= shift_r;
                `QEQ_IDX_RISE_THR: rise_thr_r <= shift_r;
                `QEQ_IDX_FALL_THR: fall_thr_r <= shift_r;
                `QEQ_IDX_SRC_SEL:  src_sel_r  <= (shift_r & `QEQ_SRC_MASK)
                                     | (`QEQ_RST_SRC & ~`QEQ_SRC_MASK);
                `QEQ_IDX_SWING:    swing_r    <= (shift_r & `QEQ_SWING_MASK)
                                     | (`QEQ_RST_SWING & ~`QEQ_SWING_MASK);
                default:           ;
            endcase
        end
    end

    // ****************************************
    // Channel outputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_ch
            logic off_bit;
            assign off_bit = (g < 2) ? ctrl_lo_r[4*(g%2)+3] : ctrl_hi_r[4*(g%2)+3];
            assign chan_active[g] = src_sel_r[0] ? !off_bit : chan_enable_pin[g];
        end
    endgenerate
    assign boost_ch0         = ctrl_lo_r[2:0];
    assign boost_ch1         = ctrl_lo_r[6:4];
    assign boost_ch2         = ctrl_hi_r[2:0];
    assign boost_ch3         = ctrl_hi_r[6:4];
    assign detect_rise_level = rise_thr_r;
    assign detect_fall_level = fall_thr_r;
    assign swing_code        = swing_r[3:2];

    // ****************************************
    // Serial slave engine
    // ****************************************
    assign wr_stb = (state_r == qeq_pkg::QEQ_WDATA) && scl_fall && (bit_cnt_r == 4'h8);
    assign rd_byte = reg_read(index_r);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r     <= qeq_pkg::QEQ_IDLE;
            index_r     <= 8'h00;
            shift_r     <= 8'h00;
            bit_cnt_r   <= 4'h0;
            reading_r   <= 1'b0;
            sda_drive_r <= 1'b0;
        end
        else if (!sel || stop_det)
        begin
            state_r     <= qeq_pkg::QEQ_IDLE;
            sda_drive_r <= 1'b0;
        end
        else if (start_det)
        begin
            state_r     <= qeq_pkg::QEQ_ADDR;
            bit_cnt_r   <= 4'h0;
            sda_drive_r <= 1'b0;
        end
        else
        begin
            if (scl_rise && (state_r == qeq_pkg::QEQ_ADDR || state_r == qeq_pkg::QEQ_IDX
                             || state_r == qeq_pkg::QEQ_WDATA))
            begin
                shift_r   <= {shift_r[6:0], sda};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            if (scl_rise && state_r == qeq_pkg::QEQ_RDATA_ACK && sda)
                state_r <= qeq_pkg::QEQ_SKIP;
            if (scl_fall)
            begin
                unique case (state_r)
                    qeq_pkg::QEQ_ADDR:
                        if (bit_cnt_r == 4'h8)
                        begin
                            if (shift_r[7:1] == `QEQ_SLAVE_ADDR)
                            begin
                                state_r     <= qeq_pkg::QEQ_ADDR_ACK;
                                reading_r   <= shift_r[0];
                                sda_drive_r <= 1'b1;
                            end
                            else
                                state_r <= qeq_pkg::QEQ_SKIP;
                        end
                    qeq_pkg::QEQ_ADDR_ACK:
                    begin
                        bit_cnt_r <= 4'h0;
                        if (reading_r)
                        begin
                            state_r     <= qeq_pkg::QEQ_RDATA;
                            shift_r     <= {rd_byte[6:0], 1'b0};
                            sda_drive_r <= !rd_byte[7];
                        end
                        else
                        begin
                            state_r     <= qeq_pkg::QEQ_IDX;
                            sda_drive_r <= 1'b0;
                        end
                    end
                    qeq_pkg::QEQ_IDX:
                        if (bit_cnt_r == 4'h8)
                        begin
                            index_r     <= shift_r;
                            state_r     <= qeq_pkg::QEQ_IDX_ACK;
                            sda_drive_r <= 1'b1;
                        end
                    qeq_pkg::QEQ_IDX_ACK:
                    begin
                        state_r     <= qeq_pkg::QEQ_WDATA;
                        bit_cnt_r   <= 4'h0;
                        sda_drive_r <= 1'b0;
                    end
                    qeq_pkg::QEQ_WDATA:
                        if (bit_cnt_r == 4'h8)
                        begin
                            state_r     <= qeq_pkg::QEQ_WDATA_ACK;
                            sda_drive_r <= 1'b1;
                        end
                    qeq_pkg::QEQ_WDATA_ACK:
                    begin
                        state_r     <= qeq_pkg::QEQ_SKIP;
                        sda_drive_r <= 1'b0;
                    end
                    qeq_pkg::QEQ_RDATA:
                        if (bit_cnt_r == 4'h7)
                        begin
                            state_r     <= qeq_pkg::QEQ_RDATA_ACK;
                            sda_drive_r <= 1'b0;
                        end
                        else
                        begin
                            sda_drive_r <= !shift_r[7];
                            shift_r     <= {shift_r[6:0], 1'b0};
                            bit_cnt_r   <= bit_cnt_r + 4'h1;
                        end
                    qeq_pkg::QEQ_RDATA_ACK:
                        state_r <= qeq_pkg::QEQ_SKIP;
                    qeq_pkg::QEQ_IDLE,
                    qeq_pkg::QEQ_SKIP:
                        ;
                endcase
            end
        end
    end
    assign bus.sda_dev_o  = 1'b0;
    assign bus.sda_dev_oe = sda_drive_r && sel;
endmodule

// File: include/qeq_consts.svh
// Constants for the quad equalizer management port
`ifndef QEQ_CONSTS_SVH
`define QEQ_CONSTS_SVH
`define QEQ_SLAVE_ADDR      7'h56
`define QEQ_IDX_STATUS0     8'h00
`define QEQ_IDX_STATUS1     8'h01
`define QEQ_IDX_STATUS2     8'h02
`define QEQ_IDX_CTRL_LO     8'h03
`define QEQ_IDX_CTRL_HI     8'h04
`define QEQ_IDX_RISE_THR    8'h05
`define QEQ_IDX_FALL_THR    8'h06
`define QEQ_IDX_SRC_SEL     8'h07
`define QEQ_IDX_SWING       8'h08
`define QEQ_RST_CTRL        8'h44
`define QEQ_RST_THR         8'h00
`define QEQ_RST_SRC         8'h00
`define QEQ_RST_SWING       8'h78
`define QEQ_SWING_MASK      8'h0C
`define QEQ_SRC_MASK        8'h01
// Arbitrary revision code
`define QEQ_REVISION        4'h1
// Quarter bit period in clocks, 100 kHz link clock
`define QEQ_CLK_DIV         16'h007D
`endif

// File: include/qeq_pkg.sv
// Types for the quad equalizer management port
package qeq_pkg;
    typedef enum logic [3:0] {
        QEQ_IDLE, QEQ_ADDR, QEQ_ADDR_ACK, QEQ_IDX, QEQ_IDX_ACK,
        QEQ_WDATA, QEQ_WDATA_ACK, QEQ_RDATA, QEQ_RDATA_ACK, QEQ_SKIP
    } qeq_slv_state_t;
    typedef enum logic [3:0] {
        QEQ_H_IDLE, QEQ_H_CSUP, QEQ_H_START, QEQ_H_BIT, QEQ_H_RSTART,
        QEQ_H_STOP, QEQ_H_CSDN
    } qeq_host_state_t;
endpackage

// File: include/qeq_if.sv
// Two-wire management link with chip-select between host and device
interface qeq_if;
    logic chip_sel;
    logic serial_clock_pin;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda;
    assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
    modport dev  (input chip_sel, input serial_clock_pin, input sda,
                  output sda_dev_o, output sda_dev_oe);
    modport host (output chip_sel, output serial_clock_pin, input sda,
                  output sda_host_o, output sda_host_oe);
endinterface

// File: hdl/qeq_host.sv
// Host master that reads and writes the equalizer registers
`include "qeq_consts.svh"
module qeq_host
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    qeq_if.host             bus,
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic [7:0] req_index,
    input  wire logic [7:0] req_wdata,
    output logic            req_ready,
    output logic            rsp_valid,
    output logic      [7:0] rsp_rdata,
    output logic            rsp_nack
);
    // ****************************************
    // Bit clock divider
    // ****************************************
    logic [15:0] div_r;
    logic        tick;
    assign tick = (div_r == 16'h0000);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= 16'h0000;
        else
            div_r <= tick ? (`QEQ_CLK_DIV - 16'h0001) : div_r - 16'h0001;
    end

    // ****************************************
    // Transaction sequencer
    // ****************************************
    // Each bit takes four ticks: phase 0 low/setup, 1 rise, 2 high sample, 3 fall
    qeq_pkg::qeq_host_state_t state_r;
    logic [1:0]  ph_r;
    logic [3:0]  bit_r;
    logic [1:0]  byte_r;
    logic [8:0]  tx_r;
    logic [7:0]  rx_r;
    logic        write_r;
    logic [7:0]  idx_r;
    logic [7:0]  wdat_r;
    logic        cs_r;
    logic        scl_r;
    logic        sda_r;
    logic        nack_r;
    logic        done_r;
    logic        sda_in_m;
    logic        sda_in;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_in_m <= 1'b1;
            sda_in   <= 1'b1;
        end
        else
        begin
            sda_in_m <= bus.sda;
            sda_in   <= sda_in_m;
        end
    end

    function automatic logic [8:0] byte_for(input logic [1:0] b, input logic wr,
                                            input logic [7:0] ix, input logic [7:0] wd);
        unique case (b)
            2'h0:    byte_for = {`QEQ_SLAVE_ADDR, 1'b0, 1'b1};
            2'h1:    byte_for = {ix, 1'b1};
            2'h2:    byte_for = wr ? {wd, 1'b1} : {`QEQ_SLAVE_ADDR, 1'b1, 1'b1};
            default: byte_for = {8'hFF, 1'b1};
        endcase
    endfunction

    assign req_ready = (state_r == qeq_pkg::QEQ_H_IDLE);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= qeq_pkg::QEQ_H_IDLE;
            ph_r    <= 2'h0;
            bit_r   <= 4'h0;
            byte_r  <= 2'h0;
            tx_r    <= 9'h1FF;
            rx_r    <= 8'h00;
            write_r <= 1'b0;
            idx_r   <= 8'h00;
            wdat_r  <= 8'h00;
            cs_r    <= 1'b0;
            scl_r   <= 1'b1;
            sda_r   <= 1'b1;
            nack_r  <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                qeq_pkg::QEQ_H_IDLE:
                    if (req_valid)
                    begin
                        write_r <= req_write;
                        idx_r   <= req_index;
                        wdat_r  <= req_wdata;
                        nack_r  <= 1'b0;
                        cs_r    <= 1'b1;
                        ph_r    <= 2'h0;
                        state_r <= qeq_pkg::QEQ_H_CSUP;
                    end
                qeq_pkg::QEQ_H_CSUP:
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        if (ph_r == 2'h3)
                        begin
                            byte_r  <= 2'h0;
                            state_r <= qeq_pkg::QEQ_H_START;
                        end
                    end
                qeq_pkg::QEQ_H_START, qeq_pkg::QEQ_H_RSTART:
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        unique case (ph_r)
                            2'h0: sda_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_r <= 1'b0;
                            2'h3:
                            begin
                                scl_r   <= 1'b0;
                                tx_r    <= byte_for(byte_r, write_r, idx_r, wdat_r);
                                bit_r   <= 4'h0;
                                state_r <= qeq_pkg::QEQ_H_BIT;
                            end
                        endcase
                    end
                qeq_pkg::QEQ_H_BIT:
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        unique case (ph_r)
                            2'h0: sda_r <= tx_r[8];
                            2'h1: scl_r <= 1'b1;
                            2'h2:
                                if (bit_r == 4'h8)
                                begin
                                    if (sda_in && byte_r != 2'h3)
                                        nack_r <= 1'b1;
                                end
                                else
                                    rx_r <= {rx_r[6:0], sda_in};
                            2'h3:
                            begin
                                scl_r <= 1'b0;
                                tx_r  <= {tx_r[7:0], 1'b1};
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == 4'h8)
                                begin
                                    byte_r <= byte_r + 2'h1;
                                    if (nack_r || byte_r == 2'h3 || (write_r && byte_r == 2'h2))
                                        state_r <= qeq_pkg::QEQ_H_STOP;
                                    else if (!write_r && byte_r == 2'h1)
                                        state_r <= qeq_pkg::QEQ_H_RSTART;
                                    else
                                    begin
                                        tx_r  <= byte_for(byte_r + 2'h1, write_r, idx_r, wdat_r);
                                        bit_r <= 4'h0;
                                    end
                                end
                            end
                        endcase
                    end
                qeq_pkg::QEQ_H_STOP:
                    if (tick)
                    begin
                        ph_r <= ph_r + 2'h1;
                        unique case (ph_r)
                            2'h0: sda_r <= 1'b0;
                            2'h1: scl_r <= 1'b1;
                            2'h2: sda_r <= 1'b1;
                            2'h3: state_r <= qeq_pkg::QEQ_H_CSDN;
                        endcase
                    end
                qeq_pkg::QEQ_H_CSDN:
                    if (tick)
                    begin
                        cs_r    <= 1'b0;
                        done_r  <= 1'b1;
                        state_r <= qeq_pkg::QEQ_H_IDLE;
                    end
                default:
                    state_r <= qeq_pkg::QEQ_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rsp_rdata <= 8'h00;
        else if ((state_r == qeq_pkg::QEQ_H_CSDN) && tick)
            rsp_rdata <= write_r ? 8'h00 : rx_r;
    end
    assign rsp_valid            = done_r;
    assign rsp_nack             = nack_r;
    assign bus.chip_sel         = cs_r;
    assign bus.serial_clock_pin = scl_r;
    assign bus.sda_host_o       = 1'b0;
    assign bus.sda_host_oe      = !sda_r;
endmodule

// File: bench/qeq_link_properties.sv
// Concurrent checks on the two-wire management link
module qeq_link_properties
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chip_sel,
    input wire logic serial_clock_pin,
    input wire logic sda_host_o,
    input wire logic sda_host_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Link sequences and checks
    // ****************************************
    sequence s_bus_idle;
        sda && serial_clock_pin;
    endsequence
    sequence s_scl_rise;
        ##[1:600] $rose(serial_clock_pin);
    endsequence
    a_dev_quiet_unsel: assert property ((!chip_sel) [*4] |-> !sda_dev_oe)
        else $error("device drives data while deselected");
    a_drive_only_sel: assert property (sda_dev_oe |-> chip_sel)
        else $error("device drives data without chip select");
    a_stop_before_desel: assert property ($fell(chip_sel) |-> ($past(sda) && $past(serial_clock_pin)))
        else $error("chip select dropped before bus release");
    a_dev_edge_low: assert property ($changed(sda_dev_oe) |-> !serial_clock_pin)
        else $error("device changed data while clock high");
    a_ack_before_rise: assert property ($rose(sda_dev_oe) |-> s_scl_rise)
        else $error("device drive not followed by clock rise");
    a_start_needs_sel: assert property (serial_clock_pin && $fell(sda) |-> chip_sel)
        else $error("start without chip select");
    a_sel_then_wait: assert property ($rose(chip_sel) |-> s_bus_idle [*8])
        else $error("bus busy right after select");
    a_idle_unsel: assert property (!chip_sel |-> s_bus_idle)
        else $error("bus not released while deselected");
endmodule

// File: bench/tb.sv
// Self-checking bench for host and device joined by the link
`include "qeq_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk           = 1'b0;
    logic       rst_n             = 1'b0;
    logic [3:0] signal_present    = 4'h0;
    logic [3:0] chan_enable_pin   = 4'h0;
    logic       req_valid         = 1'b0;
    logic       req_write         = 1'b0;
    logic [7:0] req_index         = 8'h00;
    logic [7:0] req_wdata         = 8'h00;
    logic [3:0] chan_active;
    logic [2:0] boost_ch0;
    logic [2:0] boost_ch1;
    logic [2:0] boost_ch2;
    logic [2:0] boost_ch3;
    logic [7:0] detect_rise_level;
    logic [7:0] detect_fall_level;
    logic [1:0] swing_code;
    logic       req_ready;
    logic       rsp_valid;
    logic       rsp_nack;
    logic [7:0] rsp_rdata;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [7:0] w7;
    integer     seed              = 32'hB800;
    int         n_fail            = 0;
    int         cmp_count         = 0;
    qeq_if lnk();
    always #10 sys_clk = ~sys_clk;
    qeq_dev qeq_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(lnk),
        .signal_present(signal_present), .chan_enable_pin(chan_enable_pin),
        .chan_active(chan_active), .boost_ch0(boost_ch0), .boost_ch1(boost_ch1),
        .boost_ch2(boost_ch2), .boost_ch3(boost_ch3), .detect_rise_level(detect_rise_level),
        .detect_fall_level(detect_fall_level), .swing_code(swing_code));
    qeq_host qeq_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(lnk),
        .req_valid(req_valid), .req_write(req_write), .req_index(req_index),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
    qeq_link_properties qeq_link_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .chip_sel(lnk.chip_sel), .serial_clock_pin(lnk.serial_clock_pin),
        .sda_host_o(lnk.sda_host_o), .sda_host_oe(lnk.sda_host_oe),
        .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe), .sda(lnk.sda));
    // ****************************************
    // Tasks and expectations
    // ****************************************
    function automatic logic [7:0] exp_pair(input logic [1:0] act, input logic [7:0] ctl);
        return {act[1], ctl[6:4], act[0], ctl[2:0]};
    endfunction
    function automatic logic [3:0] exp_active(input logic src, input logic [3:0] pins,
                                              input logic [7:0] lo, input logic [7:0] hi);
        return src ? {!hi[7], !hi[3], !lo[7], !lo[3]} : pins;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = w;
        req_index = ix;
        req_wdata = d;
        @(posedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 60000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 60000)
            n_fail++;
        chk({7'h00, rsp_nack}, 8'h00);
        rd = rsp_rdata;
    endtask
    task automatic print_verdict;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        chan_enable_pin = 4'($random(seed));
        signal_present = 4'($random(seed));
        @(negedge sys_clk);
        chk({2'h0, boost_ch1, boost_ch0}, 8'h24);
        chk({2'h0, boost_ch3, boost_ch2}, 8'h24);
        chk(detect_rise_level, 8'h00);
        chk(detect_fall_level, 8'h00);
        chk({6'h00, swing_code}, 8'h02);
        chk({4'h0, chan_active}, {4'h0, chan_enable_pin});
        $display("Test reset values done");
        wd = 8'($random(seed));
        wd[2:0] = 3'h0;
        wd[6:4] = 3'h7;
        xfer(1'b1, 8'h03, wd);
        chk({2'h0, boost_ch1, boost_ch0}, {2'h0, wd[6:4], wd[2:0]});
        chk({4'h0, chan_active}, {4'h0, chan_enable_pin});
        $display("Test register write done");
        chan_enable_pin = 4'($random(seed));
        xfer(1'b0, 8'h01, 8'h00);
        chk(rd, exp_pair(chan_enable_pin[1:0], wd));
        $display("Test status read done");
        w7 = 8'($random(seed)) | 8'h01;
        xfer(1'b1, 8'h07, w7);
        chk({4'h0, chan_active}, {4'h0, exp_active(1'b1, chan_enable_pin, wd, `QEQ_RST_CTRL)});
        xfer(1'b0, 8'h07, 8'h00);
        chk(rd, 8'h01);
        $display("Test control source done");
        signal_present = 4'($random(seed));
        xfer(1'b0, 8'h00, 8'h00);
        chk(rd, {`QEQ_REVISION, signal_present});
        $display("Test revision read done");
        print_verdict();
    end
    initial
    begin
        #(20 * 100000);
        n_fail++;
        print_verdict();
    end
endmodule
